// File: src/gra_addr_select.sv
/*
 General register scratchpad address select for a duplicated register file.
 Produces source and destination addresses, byte write enables, the stack
 pointer indication and altered register flags. Assumes all control inputs
 come from microprogram logic on clk_i, and cycle pulses are one clock wide.
*/
`timescale 1ns/100ps
`include "gra_defines.svh"

// How it works
// - Two copies of sixteen registers addressed, two sets of eight registers.
// - Nothing stops copies differing on writes; microprogram keeps them equal.
// - Three-bit select field chooses seven source combinations; value 3 unused.
// - Select 0 puts the source field on both addresses.
// - Select 2 puts constant register 5 on both addresses.
// - Select 5 puts the destination field on both addresses.
// - Select 7 puts constant 6, the stack pointer, on both addresses.
// - Select 6 disables the multiplexers, addressing register 0.
// - Select 1 gives destination field for destination, source field for source.
// - Select 4 forces the source field low bit to one.
// - Top address bit picks the set; set 0 forced in special cases.
// - Status bit 11 with registers 0 to 5 selects set 1.
// - Register 6 in supervisor gives address 16, user gives 17.
// - Previous-space move of register 6 uses previous mode stack pointer.
// - Set bit follows field sets, current mode for 6, status bit for 5.
// - Console access uses instruction bit 3 as set; the register comes from the select field, bits 2:0 with select 5.
// - Stack pointer in use flag whenever register 6 is addressed.
// - Post-cycle clock is issued after cycle end for condition codes.
// - Byte write enables decoded; conditional needs condition and no abort, unconditional needs no abort.
// - Write at cycle end; enables latched, cleared by the post-cycle pulse.
// - Four altered register flags go to the memory management unit.
// - Both copies receive every write; each has its own address, source or destination.
module gra_addr_select (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Microprogram controls
   input wire logic [2:0] addr_sel_i,
   input wire logic [1:0] hi_we_ctl_i,
   input wire logic [1:0] lo_we_ctl_i,
   input wire logic write_cond_i,
   input wire logic mmu_abort_i,
   input wire logic cycle_end_pulse_i,
   input wire logic post_cycle_pulse_i,
   input wire logic new_instr_i,
   // Instruction and status
   input wire logic [15:0] instruction_reg_i,
   input wire logic [15:0] processor_status_i,
   input wire logic move_from_previous_space_instr_i,
   input wire logic console_reg_examine_i,
   input wire logic console_reg_deposit_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Scratchpad addressing and write strobes
   output logic [3:0] src_addr_o,
   output logic [3:0] dst_addr_o,
   output logic high_byte_write_en_o,
   output logic low_byte_write_en_o,
   output logic stack_ptr_in_use_o,
   output logic post_cycle_clock_o,
   output logic post_cycle_gate_o,
   output logic [3:0] altered_reg_addr_flags_o
);
   // ************************************************************
   // Declarations
   // ************************************************************
   logic [1:0] ctrl_reg;
   logic [3:0] src_addr_next;
   logic [3:0] dst_addr_next;
   logic [1:0] src_sel;
   logic [1:0] dst_sel;
   logic mux_en;
   logic force_odd_addr;
   logic console;
   logic [2:0] src_field;
   logic [2:0] dst_field;
   logic alt_set_status_bit;
   logic [1:0] cur_mode;
   logic [1:0] prev_mode;
   logic src_set_one_sel;
   logic dst_set_one_sel;
   logic five_set;
   logic six_set;
   logic six_odd;
   logic src_user_sp;
   logic dst_user_sp;
   logic mfp_sp;
   logic [1:0] sp_mode;
   logic hi_ok;
   logic lo_ok;
   logic hi_latch_reg;
   logic lo_latch_reg;
   gra_pkg::wr_state_t wr_state_reg;
   logic wb_hit;

   // ************************************************************
   // Field and mode decode
   // ************************************************************
   assign console = console_reg_examine_i || console_reg_deposit_i;
   assign src_field = instruction_reg_i[8:6];
   assign dst_field = instruction_reg_i[2:0];
   assign alt_set_status_bit = processor_status_i[`PS_SET_BIT];
   assign cur_mode = processor_status_i[`PS_CUR_HI:`PS_CUR_LO];
   assign prev_mode = processor_status_i[`PS_PREV_HI:`PS_PREV_LO];
   // Previous-space move reads the previous mode stack from the dest field
   assign mfp_sp = move_from_previous_space_instr_i && dst_field == `REG_SP;

   // Set 1 for R0-R5 under the status bit, or R6 outside kernel mode
   always_comb begin
      src_set_one_sel = 1'b0;
      dst_set_one_sel = 1'b0;
      sp_mode = mfp_sp ? prev_mode : cur_mode;
      if (!console) begin
         if (src_field < `REG_SP)
            src_set_one_sel = alt_set_status_bit;
         else if (src_field == `REG_SP)
            src_set_one_sel = cur_mode != `MODE_KERNEL;
         if (dst_field < `REG_SP)
            dst_set_one_sel = alt_set_status_bit;
         else if (dst_field == `REG_SP)
            dst_set_one_sel = sp_mode != `MODE_KERNEL;
      end
   end

   // Constant sources: 6 follows mode (kernel forces set 0), 5 follows status
   assign six_set = !console && cur_mode != `MODE_KERNEL;
   assign five_set = !console && alt_set_status_bit;
   assign six_odd = !console && cur_mode == `MODE_USER;
   // Field-named R6 in user mode is the odd location too: address 17
   assign src_user_sp = !console && src_field == `REG_SP && cur_mode == `MODE_USER;
   assign dst_user_sp = !console && dst_field == `REG_SP && sp_mode == `MODE_USER;

   // ************************************************************
   // Multiplexer control from the select field
   // ************************************************************
   always_comb begin
      dst_sel = 2'h0;
      mux_en = 1'b1;
      force_odd_addr = 1'b0;
      case (addr_sel_i)
         `SEL_SRC_BOTH: dst_sel = 2'h0;
         `SEL_SPLIT: dst_sel = 2'h1;
         `SEL_CONST5: dst_sel = 2'h2;
         `SEL_ODD_SRC: begin
            dst_sel = 2'h0;
            force_odd_addr = 1'b1;
         end
         `SEL_DST_BOTH: dst_sel = 2'h1;
         `SEL_ZERO: mux_en = 1'b0;
         `SEL_CONST6: dst_sel = 2'h3;
         default: mux_en = 1'b0;
      endcase
   end
   // Source multiplexer low select forced to zero for the split case
   assign src_sel = {dst_sel[1], dst_sel[0] && addr_sel_i != `SEL_SPLIT};

   // Source and destination multiplexer instances
   gra_addr_mux u_src_mux (
      .sel_i(src_sel),
      .enable_i(mux_en),
      .force_odd_i(force_odd_addr || src_user_sp),
      .src_field_i(src_field),
      .dst_field_i({dst_field[2:1], dst_field[0] | dst_user_sp}),
      .src_set_i(src_set_one_sel),
      .dst_set_i(dst_set_one_sel),
      .five_set_i(five_set),
      .six_set_i(six_set),
      .six_odd_i(six_odd),
      .addr_o(src_addr_next)
   );
   gra_addr_mux u_dst_mux (
      .sel_i(dst_sel),
      .enable_i(mux_en),
      .force_odd_i(force_odd_addr || src_user_sp),
      .src_field_i(src_field),
      .dst_field_i({dst_field[2:1], dst_field[0] | dst_user_sp}),
      .src_set_i(src_set_one_sel),
      .dst_set_i(dst_set_one_sel),
      .five_set_i(five_set),
      .six_set_i(six_set),
      .six_odd_i(six_odd),
      .addr_o(dst_addr_next)
   );

   // ************************************************************
   // Registered addresses
   // ************************************************************
   // Console gates instruction bit 3 straight onto the set bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_addr_o <= 4'h0;
         dst_addr_o <= 4'h0;
         stack_ptr_in_use_o <= 1'b0;
      end else begin
         if (console) begin
            src_addr_o <= {instruction_reg_i[3], src_addr_next[2:0]};
            dst_addr_o <= {instruction_reg_i[3], dst_addr_next[2:0]};
         end else begin
            src_addr_o <= src_addr_next;
            dst_addr_o <= dst_addr_next;
         end
         // User stack pointer sits at 17, whose low bits read as 7
         stack_ptr_in_use_o <= src_addr_next[2:0] == `REG_SP
            || dst_addr_next[2:0] == `REG_SP
            || src_addr_next == 4'hF || dst_addr_next == 4'hF;
      end
   end

   // ************************************************************
   // Byte write enables
   // ************************************************************
   // Conditional write needs the condition and no abort; unconditional needs no abort
   assign hi_ok = (hi_we_ctl_i == `WE_UNCOND && !mmu_abort_i)
      || (hi_we_ctl_i == `WE_COND && write_cond_i && !mmu_abort_i);
   assign lo_ok = (lo_we_ctl_i == `WE_UNCOND && !mmu_abort_i)
      || (lo_we_ctl_i == `WE_COND && write_cond_i && !mmu_abort_i);

   // Latch at cycle end, hold until the post-cycle pulse clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_latch_reg <= 1'b0;
         lo_latch_reg <= 1'b0;
         wr_state_reg <= gra_pkg::WR_IDLE;
      end else begin
         case (wr_state_reg)
            gra_pkg::WR_IDLE: begin
               if (cycle_end_pulse_i && (hi_ok || lo_ok)) begin
                  hi_latch_reg <= hi_ok;
                  lo_latch_reg <= lo_ok;
                  wr_state_reg <= gra_pkg::WR_HOLD;
               end
            end
            gra_pkg::WR_HOLD: begin
               if (post_cycle_pulse_i) begin
                  hi_latch_reg <= 1'b0;
                  lo_latch_reg <= 1'b0;
                  wr_state_reg <= gra_pkg::WR_IDLE;
               end
            end
            default: wr_state_reg <= gra_pkg::WR_IDLE;
         endcase
      end
   end

   // One strobe per byte feeds both copies; their two addresses can differ on a write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_byte_write_en_o <= 1'b0;
         low_byte_write_en_o <= 1'b0;
      end else begin
         high_byte_write_en_o <= hi_latch_reg && ctrl_reg[0];
         low_byte_write_en_o <= lo_latch_reg && ctrl_reg[0];
      end
   end

   // ************************************************************
   // Post-cycle clock and altered register flags
   // ************************************************************
   // Issued after cycle end so condition codes survive a stalled cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         post_cycle_clock_o <= 1'b0;
         post_cycle_gate_o <= 1'b0;
      end else begin
         post_cycle_clock_o <= post_cycle_pulse_i;
         post_cycle_gate_o <= wr_state_reg == gra_pkg::WR_HOLD || post_cycle_pulse_i;
      end
   end

   // Sticky per instruction; a write in the same cycle as the clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         altered_reg_addr_flags_o <= 4'h0;
      end else if (cycle_end_pulse_i && (hi_ok || lo_ok) && wr_state_reg == gra_pkg::WR_IDLE) begin
         altered_reg_addr_flags_o <= dst_addr_o;
      end else if (new_instr_i) begin
         altered_reg_addr_flags_o <= 4'h0;
      end
   end

   // ************************************************************
   // Wishbone slave: control and status
   // ************************************************************
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Ack one cycle after the strobe; drops the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_hit;
   end

   // Bit 0 allows writes; bit 1 is spare scratch
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ctrl_reg <= `CTRL_RESET;
      else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_CTRL)
         ctrl_reg <= wb_dat_i[1:0];
   end

   // Read data; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (wb_hit && !wb_we_i) begin
         case (wb_adr_i)
            `OFS_CTRL: wb_dat_o <= {30'h0, ctrl_reg};
            `OFS_STATUS: wb_dat_o <= {20'h0, wr_state_reg, hi_latch_reg, lo_latch_reg,
               dst_addr_o, src_addr_o};
            `OFS_ALTERED: wb_dat_o <= {28'h0, altered_reg_addr_flags_o};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   zero_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_ZERO && !console |=> src_addr_o == 4'h0 && dst_addr_o == 4'h0)
      else $error("select 6 did not give register 0");
   const_five_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_CONST5 |=> src_addr_o[2:0] == 3'h5 && dst_addr_o[2:0] == 3'h5)
      else $error("select 2 did not give register 5");
   split_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_SPLIT
      |=> src_addr_o[2:0] == ($past(src_field) | {2'h0, $past(src_user_sp)})
      && dst_addr_o[2:0] == ($past(dst_field) | {2'h0, $past(dst_user_sp)}))
      else $error("split select wrong");
   odd_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_ODD_SRC |=> src_addr_o[0] && dst_addr_o[0])
      else $error("force odd missing");
   user_sp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_CONST6 && !console && cur_mode == `MODE_USER
      |=> dst_addr_o == 4'hF)
      else $error("user stack pointer not at 17");
   sp_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_sel_i == `SEL_CONST6 |=> stack_ptr_in_use_o)
      else $error("stack pointer flag missing");
   abort_we_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_state_reg == gra_pkg::WR_IDLE && cycle_end_pulse_i && mmu_abort_i
      |=> !hi_latch_reg && !lo_latch_reg)
      else $error("write enable set despite abort");
   we_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_state_reg == gra_pkg::WR_HOLD && post_cycle_pulse_i
      |=> ##1 !high_byte_write_en_o && !low_byte_write_en_o)
      else $error("write enable not cleared by post-cycle pulse");
endmodule // gra_addr_select

// File: src/gra_defines.svh
/*
 Constants for the general register address select block: field encodings,
 register numbers, status bit positions and Wishbone register offsets.
 Assumes inclusion by bare name from the design modules and the testbench.
*/
`ifndef GRA_DEFINES_SVH
`define GRA_DEFINES_SVH

// ************************************************************
// Address select field encodings
// ************************************************************
`define SEL_SRC_BOTH 3'h0
`define SEL_SPLIT 3'h1
`define SEL_CONST5 3'h2
`define SEL_UNUSED 3'h3
`define SEL_ODD_SRC 3'h4
`define SEL_DST_BOTH 3'h5
`define SEL_ZERO 3'h6
`define SEL_CONST6 3'h7

// ************************************************************
// Register numbers and status bits
// ************************************************************
`define REG_FIVE 3'h5
`define REG_SP 3'h6
`define REG_ZERO 3'h0
`define PS_SET_BIT 11
`define PS_CUR_HI 15
`define PS_CUR_LO 14
`define PS_PREV_HI 13
`define PS_PREV_LO 12
`define MODE_KERNEL 2'h0
`define MODE_SUPER 2'h1
`define MODE_USER 2'h3

// ************************************************************
// Write enable field encodings
// ************************************************************
`define WE_NONE 2'h0
`define WE_UNCOND 2'h1
`define WE_COND 2'h2

// ************************************************************
// Wishbone register offsets (byte addresses) and reset values
// ************************************************************
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_ALTERED 4'h8
`define CTRL_RESET 2'h0
`define WB_ADR_W 4

`endif

// File: src/gra_pkg.sv
/*
 Types shared by the address select block.
 Assumes the defines header is available on the include path.
*/
package gra_pkg;
   // Write phase of the latched byte enables
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_ARMED,
      WR_HOLD
   } wr_state_t;
   // Register address: set bit plus register number
   typedef logic [3:0] pad_addr_t;
endpackage

// File: src/gra_addr_mux.sv
/*
 One scratchpad address multiplexer with its register set selection.
 Assumes select inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "gra_defines.svh"

module gra_addr_mux (
   // Multiplexer controls
   input wire logic [1:0] sel_i,
   input wire logic enable_i,
   input wire logic force_odd_i,
   // Data inputs: source field, destination field, constants
   input wire logic [2:0] src_field_i,
   input wire logic [2:0] dst_field_i,
   input wire logic src_set_i,
   input wire logic dst_set_i,
   input wire logic five_set_i,
   input wire logic six_set_i,
   input wire logic six_odd_i,
   // Result
   output logic [3:0] addr_o
);
   logic [2:0] reg_num;
   logic set_bit;

   // Four-input selection; disabled yields register 0 of set 0
   always_comb begin
      reg_num = `REG_ZERO;
      set_bit = 1'b0;
      if (enable_i) begin
         case (sel_i)
            2'h0: begin
               reg_num = src_field_i | {2'h0, force_odd_i};
               set_bit = src_set_i;
            end
            2'h1: begin
               reg_num = dst_field_i;
               set_bit = dst_set_i;
            end
            2'h2: begin
               reg_num = `REG_FIVE;
               set_bit = five_set_i;
            end
            default: begin
               reg_num = `REG_SP;
               set_bit = six_set_i;
            end
         endcase
      end
   end

   // User stack pointer is the odd one: address 17 (octal)
   assign addr_o = {set_bit, reg_num[2:1],
      reg_num[0] | (enable_i && sel_i == 2'h3 && six_odd_i)};
endmodule // gra_addr_mux

// File: testbench/gra_seq_model.sv
/*
 Behavioural model of the microprogram timing that brackets a register write:
 one cycle-end pulse, then a post-cycle pulse a few cycles later.
 Assumes go_i is raised for one clock just after a rising edge.
*/
`timescale 1ns/100ps

module gra_seq_model #(
   parameter int HOLD_CYCLES = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request from the bench
   input wire logic go_i,
   // Timing pulses toward the block
   output logic cycle_end_pulse_o,
   output logic post_cycle_pulse_o,
   output logic busy_o
);
   logic [3:0] count_reg;

   // ************************************************************
   // Pulse sequencer
   // ************************************************************
   // Post pulse lags the write point so the latched enables must hold
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cycle_end_pulse_o <= 1'b0;
         post_cycle_pulse_o <= 1'b0;
         busy_o <= 1'b0;
         count_reg <= 4'h0;
      end else begin
         cycle_end_pulse_o <= go_i && !busy_o;
         post_cycle_pulse_o <= busy_o && (count_reg == 4'h1);
         if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            count_reg <= 4'(HOLD_CYCLES);
         end else if (busy_o) begin
            count_reg <= count_reg - 4'h1;
            if (count_reg == 4'h1) begin
               busy_o <= 1'b0;
            end
         end
      end
   end
endmodule // gra_seq_model

// File: testbench/test_gra_addr_select.sv
/*
 Self-checking bench for the address select block: table of address cases,
 then console, write enable, abort and altered flag cases.
 Assumes the defines header on the include path and the sequencer model.
*/
`timescale 1ns/100ps
`include "gra_defines.svh"

module test_gra_addr_select;
   typedef struct packed {
      logic [2:0] sel;
      logic [15:0] ir;
      logic [15:0] ps;
      logic [3:0] src;
      logic [3:0] dst;
      logic sp;
   } row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] addr_sel_i = 3'h0;
   logic [1:0] hi_we_ctl_i = 2'h0;
   logic [1:0] lo_we_ctl_i = 2'h0;
   logic write_cond_i = 1'b0;
   logic mmu_abort_i = 1'b0;
   logic new_instr_i = 1'b0;
   logic [15:0] instruction_reg_i = 16'h0000;
   logic [15:0] processor_status_i = 16'h0000;
   logic mfp_i = 1'b0;
   logic exam_i = 1'b0;
   logic dep_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, go_i, cyc_end, post_pulse;
   logic [3:0] src_addr_o, dst_addr_o, altered_o, seen;
   logic hi_we_o, lo_we_o, sp_o, post_clk_o, gate_o;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   row_t rows[13] = '{
      '{3'h0, 16'h00C2, 16'h0000, 4'h3, 4'h3, 1'b0}, '{3'h1, 16'h00C2, 16'h0000, 4'h3, 4'h2, 1'b0},
      '{3'h2, 16'h00C2, 16'h0000, 4'h5, 4'h5, 1'b0}, '{3'h4, 16'h0083, 16'h0000, 4'h3, 4'h3, 1'b0},
      '{3'h5, 16'h00C2, 16'h0000, 4'h2, 4'h2, 1'b0}, '{3'h6, 16'h00C2, 16'h0000, 4'h0, 4'h0, 1'b0},
      '{3'h7, 16'h00C2, 16'h0000, 4'h6, 4'h6, 1'b1}, '{3'h7, 16'h00C2, 16'h4000, 4'hE, 4'hE, 1'b1},
      '{3'h7, 16'h00C2, 16'hC000, 4'hF, 4'hF, 1'b1}, '{3'h2, 16'h00C2, 16'h0800, 4'hD, 4'hD, 1'b0},
      '{3'h1, 16'h00C2, 16'h0800, 4'hB, 4'hA, 1'b0}, '{3'h0, 16'h0182, 16'h4000, 4'hE, 4'hE, 1'b1},
      '{3'h5, 16'h0006, 16'hC000, 4'hF, 4'hF, 1'b1}};

   gra_seq_model u_gra_seq_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_i),
      .cycle_end_pulse_o(cyc_end), .post_cycle_pulse_o(post_pulse), .busy_o());

   gra_addr_select u_gra_addr_select (.clk_i(clk_i), .rst_i(rst_i), .addr_sel_i(addr_sel_i),
      .hi_we_ctl_i(hi_we_ctl_i), .lo_we_ctl_i(lo_we_ctl_i), .write_cond_i(write_cond_i),
      .mmu_abort_i(mmu_abort_i), .cycle_end_pulse_i(cyc_end), .post_cycle_pulse_i(post_pulse),
      .new_instr_i(new_instr_i), .instruction_reg_i(instruction_reg_i),
      .processor_status_i(processor_status_i), .move_from_previous_space_instr_i(mfp_i),
      .console_reg_examine_i(exam_i), .console_reg_deposit_i(dep_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_addr_o(src_addr_o),
      .dst_addr_o(dst_addr_o), .high_byte_write_en_o(hi_we_o), .low_byte_write_en_o(lo_we_o),
      .stack_ptr_in_use_o(sp_o), .post_cycle_clock_o(post_clk_o), .post_cycle_gate_o(gate_o),
      .altered_reg_addr_flags_o(altered_o));

   // ************************************************************
   // Clock, timeout and shared tasks
   // ************************************************************
   always #10 clk_i = ~clk_i;

   // Ceiling well above the hundred or so cycles the sequence needs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic chk_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled, then one idle cycle
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic run_cycle();
      go_i <= 1'b1;
      @(posedge clk_i);
      go_i <= 1'b0;
   endtask

   // Bounded poll; enables are levels so a late match still counts
   task automatic wait_we(input logic [1:0] want);
      for (int n = 0; n < 8 && {hi_we_o, lo_we_o} !== want; n++) @(posedge clk_i);
      chk_nib("write_enables", {2'h0, want}, {2'h0, hi_we_o, lo_we_o});
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      go_i = 1'b0;
      repeat (10) @(posedge clk_i);
      chk_nib("reset_outputs", 4'h0, {hi_we_o, lo_we_o, sp_o, post_clk_o});
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         addr_sel_i <= rows[i].sel;
         instruction_reg_i <= rows[i].ir;
         processor_status_i <= rows[i].ps;
         repeat (2) @(posedge clk_i);
         chk_nib("src_addr", rows[i].src, src_addr_o);
         chk_nib("dst_addr", rows[i].dst, dst_addr_o);
         chk_nib("sp_in_use", {3'h0, rows[i].sp}, {3'h0, sp_o});
      end
      // Previous-space move of R6 follows the previous mode, here user
      mfp_i <= 1'b1;
      addr_sel_i <= `SEL_DST_BOTH;
      instruction_reg_i <= 16'h0006;
      processor_status_i <= 16'h3000;
      repeat (2) @(posedge clk_i);
      chk_nib("mfp_src", 4'hF, src_addr_o);
      mfp_i <= 1'b0;
      // Console access: set bit comes only from instruction bit 3
      for (int k = 0; k < 2; k++) begin
         exam_i <= (k == 0);
         dep_i <= (k == 1);
         addr_sel_i <= `SEL_DST_BOTH;
         instruction_reg_i <= (k == 0) ? 16'h000A : 16'h0002;
         processor_status_i <= 16'h0800;
         repeat (2) @(posedge clk_i);
         chk_nib("console_dst", (k == 0) ? 4'hA : 4'h2, dst_addr_o);
         chk_nib("console_src", (k == 0) ? 4'hA : 4'h2, src_addr_o);
      end
      exam_i <= 1'b0;
      dep_i <= 1'b0;
      wb_xfer(1'b0, `OFS_CTRL, 32'h0);
      chk_word("ctrl_reset", 32'h0, rd);
      wb_xfer(1'b1, `OFS_CTRL, 32'h1);
      wb_xfer(1'b0, 4'hC, 32'h0);
      chk_word("unmapped_read", 32'h0, rd);
      addr_sel_i <= `SEL_SPLIT;
      instruction_reg_i <= 16'h00C2;
      processor_status_i <= 16'h0000;
      hi_we_ctl_i <= `WE_UNCOND;
      lo_we_ctl_i <= `WE_COND;
      @(posedge clk_i);
      run_cycle();
      wait_we(2'b10);
      chk_nib("post_cycle_gate", 4'h1, {3'h0, gate_o});
      for (int n = 0; n < 8 && post_clk_o !== 1'b1; n++) @(posedge clk_i);
      chk_nib("post_cycle_clock", 4'h1, {3'h0, post_clk_o});
      wait_we(2'b00);
      chk_nib("post_cycle_gate_low", 4'h0, {3'h0, gate_o});
      chk_nib("altered_flags", 4'h2, altered_o);
      wb_xfer(1'b0, `OFS_ALTERED, 32'h0);
      chk_word("altered_read", 32'h2, rd);
      wb_xfer(1'b0, `OFS_STATUS, 32'h0);
      chk_word("status_read", 32'h23, rd);
      // Abort must block the unconditional write entirely
      mmu_abort_i <= 1'b1;
      lo_we_ctl_i <= `WE_NONE;
      seen = 4'h0;
      run_cycle();
      repeat (10) begin
         @(posedge clk_i);
         seen = seen | {2'h0, hi_we_o, lo_we_o};
      end
      chk_nib("abort_enables", 4'h0, seen);
      mmu_abort_i <= 1'b0;
      hi_we_ctl_i <= `WE_NONE;
      lo_we_ctl_i <= `WE_COND;
      write_cond_i <= 1'b1;
      @(posedge clk_i);
      run_cycle();
      wait_we(2'b01);
      wait_we(2'b00);
      new_instr_i <= 1'b1;
      @(posedge clk_i);
      new_instr_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk_nib("altered_cleared", 4'h0, altered_o);
      tally_and_finish();
   end
endmodule // test_gra_addr_select
